/* File: hw/rsac_pkg.sv */
package rsac_pkg;

   // ********************************
   // Widths and parsed command codes
   // ********************************
   localparam int VAL_W = 16;

   typedef enum logic [4:0] {
      CMD_NONE         = 5'h00,
      CMD_CLEAR_STATUS = 5'h01,
      CMD_EVMASK_WR    = 5'h02,
      CMD_EVMASK_RD    = 5'h03,
      CMD_EVFLAGS_RD   = 5'h04,
      CMD_DONE_WR      = 5'h05,
      CMD_DONE_RD      = 5'h06,
      CMD_RESET        = 5'h07,
      CMD_SRMASK_WR    = 5'h08,
      CMD_SRMASK_RD    = 5'h09,
      CMD_STATUS_RD    = 5'h0a,
      CMD_SELFTEST_RD  = 5'h0b,
      CMD_ALARM_CFG_WR = 5'h0c,
      CMD_ALARM_STATE  = 5'h0d,
      CMD_ALARM_CLEAR  = 5'h0e,
      CMD_AUX_CFG_WR   = 5'h0f,
      CMD_AUX_LEVEL_RD = 5'h10,
      CMD_SOUNDER_WR   = 5'h11,
      CMD_SOUNDER_RD   = 5'h12,
      CMD_DISPLAY_WR   = 5'h13,
      CMD_DISPLAY_RD   = 5'h14,
      CMD_LOOP_MODE_WR = 5'h15,
      CMD_LOOP_MODE_RD = 5'h16
   } rsac_cmd_e;

   // ********************************
   // Event flag and status byte bit positions
   // ********************************
   localparam int EV_DONE_BIT  = 0;
   localparam int EV_DEV_BIT   = 3;
   localparam int EV_EXEC_BIT  = 4;
   localparam int EV_PWR_BIT   = 7;
   localparam int SB_NEW_BIT   = 0;
   localparam int SB_ALARM_BIT = 3;
   localparam int SB_ERR_BIT   = 4;
   localparam int SB_RQS_BIT   = 6;

   // ********************************
   // Reset values and legal code ranges
   // ********************************
   localparam logic [7:0] MASK_RST      = 8'h00;
   localparam logic [1:0] BRIGHT_RST    = 2'h2;
   localparam logic [1:0] BRIGHT_MAX    = 2'h3;
   localparam logic       SOUNDER_RST   = 1'b1;
   localparam logic [2:0] LOOP_MODE_RST = 3'h1;
   localparam logic [2:0] LOOP_MODE_MIN = 3'h1;
   localparam logic [2:0] LOOP_MODE_MAX = 3'h6;
   localparam logic [2:0] SRC_MIN       = 3'h1;
   localparam logic [2:0] SRC_MAX       = 3'h4;
   localparam logic [2:0] SRC_RST       = 3'h1;
   localparam logic [1:0] AUX_OFF       = 2'h0;
   localparam logic [1:0] AUX_INPUT     = 2'h1;
   localparam logic [1:0] AUX_MANUAL    = 2'h2;
   localparam logic [1:0] AUX_LOOP      = 2'h3;

   // ********************************
   // Output level scale, in tenths of a percent
   // ********************************
   localparam int PCT_FULL  = 1000;
   localparam int PCT_SPAN2 = 2000;
   localparam int PCT_STEP  = 5;

endpackage

/* File: hw/rsac_cmd_core.sv */
module rsac_cmd_core
#(
   parameter int W = rsac_pkg::VAL_W
) (
   input  wire logic                    i_clk,
   input  wire logic                    i_sys_rst,
   input  wire logic                    i_cmd_valid,
   input  wire rsac_pkg::rsac_cmd_e     i_cmd_code,
   input  wire logic                    i_cmd_sel,
   input  wire logic [7:0]              i_arg_num,
   input  wire logic                    i_arg_en,
   input  wire logic [2:0]              i_arg_src,
   input  wire logic                    i_arg_latch,
   input  wire logic signed [W-1:0]     i_val_hi,
   input  wire logic signed [W-1:0]     i_val_lo,
   input  wire logic signed [W-1:0]     i_val_db,
   input  wire logic signed [W-1:0]     i_val_man,
   input  wire logic                    i_rdg_valid,
   input  wire logic                    i_rdg_chan,
   input  wire logic [2:0]              i_rdg_src,
   input  wire logic signed [W-1:0]     i_rdg_val,
   input  wire logic signed [W-1:0]     i_loop_out,
   input  wire logic                    i_op_busy,
   input  wire logic                    i_dev_err,
   input  wire logic                    i_exe_err,
   input  wire logic                    i_selftest_fail,
   output logic                         o_rsp_valid,
   output rsac_pkg::rsac_cmd_e          o_rsp_code,
   output logic signed [W-1:0]          o_rsp_val,
   output logic                         o_rsp_aux,
   output logic                         o_srq,
   output logic [1:0]                   o_alarm_hi,
   output logic [1:0]                   o_alarm_lo,
   output logic                         o_sounder,
   output logic [1:0]                   o_display_level,
   output logic [2:0]                   o_loop1_mode,
   output logic [2:0]                   o_loop2_mode,
   output logic signed [W-1:0]          o_aux_level
);
   import rsac_pkg::*;

   // ********************************
   // Helper functions
   // ********************************

   // Source selector is legal for alarm checking and readings.
   function automatic logic src_ok(input logic [2:0] s);
      src_ok = (s >= SRC_MIN) && (s <= SRC_MAX);
   endfunction

   // Limits a level to the output range for the given polarity.
   function automatic logic signed [31:0] clamp_pct(input logic signed [31:0] v,
                                                    input logic bip);
      logic signed [31:0] lo;
      lo = bip ? -32'(PCT_FULL) : 32'sd0;
      if (v > 32'(PCT_FULL)) begin
         clamp_pct = 32'(PCT_FULL);
      end else if (v < lo) begin
         clamp_pct = lo;
      end else begin
         clamp_pct = v;
      end
   endfunction

   // ********************************
   // Command strobes
   // ********************************
   logic cmd_clr, cmd_rst, cmd_almclr;

   assign cmd_clr    = i_cmd_valid && (i_cmd_code == CMD_CLEAR_STATUS);
   assign cmd_rst    = i_cmd_valid && (i_cmd_code == CMD_RESET);
   assign cmd_almclr = i_cmd_valid && (i_cmd_code == CMD_ALARM_CLEAR);

   // ********************************
   // Masks, event flags and status byte
   // ********************************
   logic [7:0] ev_mask_q, sr_mask_q, ev_flags_q, ev_set;
   logic       pwr_seen_q, tst_fail_q, new_q, srq_q;
   logic [1:0] seen_q, alm_hi_q, alm_lo_q;
   logic       done_cmd_q, done_qry_q, done_ev, done_rsp, imm_rsp;
   logic [7:0] status_byte;

   // Masks survive the reset command; only power-up clears them.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ev_mask_q <= MASK_RST;
         sr_mask_q <= MASK_RST;
      end else if (i_cmd_valid && (i_cmd_code == CMD_EVMASK_WR)) begin
         ev_mask_q <= i_arg_num;
      end else if (i_cmd_valid && (i_cmd_code == CMD_SRMASK_WR)) begin
         sr_mask_q <= i_arg_num;
      end
   end

   // Self-test result and power-on event are caught once after release.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pwr_seen_q <= 1'b0;
         tst_fail_q <= 1'b0;
      end else if (!pwr_seen_q) begin
         pwr_seen_q <= 1'b1;
         tst_fail_q <= i_selftest_fail;
      end
   end

   // Pending completion requests wait for all selected work to end.
   assign done_ev  = done_cmd_q && !i_op_busy;
   assign done_rsp = done_qry_q && !i_op_busy;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst || cmd_clr) begin
         done_cmd_q <= 1'b0;
      end else if (i_cmd_valid && (i_cmd_code == CMD_DONE_WR)) begin
         done_cmd_q <= 1'b1;
      end else if (done_ev) begin
         done_cmd_q <= 1'b0;
      end
   end

   // A query answer stays pending for as long as other answers take the slot.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || cmd_clr) begin
         done_qry_q <= 1'b0;
      end else if (i_cmd_valid && (i_cmd_code == CMD_DONE_RD)) begin
         done_qry_q <= 1'b1;
      end else if (done_rsp && !imm_rsp) begin
         done_qry_q <= 1'b0;
      end
   end

   // New events win over a clear or a read in the same cycle.
   always_comb begin
      ev_set              = 8'h00;
      ev_set[EV_DONE_BIT] = done_ev;
      ev_set[EV_DEV_BIT]  = i_dev_err;
      ev_set[EV_EXEC_BIT] = i_exe_err;
      ev_set[EV_PWR_BIT]  = !pwr_seen_q;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ev_flags_q <= 8'h00;
      end else if (cmd_clr || (i_cmd_valid && (i_cmd_code == CMD_EVFLAGS_RD))) begin
         ev_flags_q <= ev_set;
      end else begin
         ev_flags_q <= ev_flags_q | ev_set;
      end
   end

   // New-reading bit rises once both inputs have reported; that wins over a clear.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         seen_q <= 2'b00;
         new_q  <= 1'b0;
      end else if (i_rdg_valid && ((seen_q | (2'b01 << i_rdg_chan)) == 2'b11)) begin
         seen_q <= 2'b00;
         new_q  <= 1'b1;
      end else if (cmd_clr) begin
         seen_q <= 2'b00;
         new_q  <= 1'b0;
      end else if (i_rdg_valid) begin
         seen_q <= seen_q | (2'b01 << i_rdg_chan);
      end
   end

   // Status byte is assembled from live state; reading it clears nothing.
   always_comb begin
      status_byte               = 8'h00;
      status_byte[SB_NEW_BIT]   = new_q;
      status_byte[SB_ALARM_BIT] = |{alm_hi_q, alm_lo_q};
      status_byte[SB_ERR_BIT]   = |(ev_flags_q & ev_mask_q);
      status_byte[SB_RQS_BIT]   = srq_q;
   end

   // Service request follows the enabled summary bits.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         srq_q <= 1'b0;
      end else begin
         srq_q <= |(status_byte & sr_mask_q & ~(8'h01 << SB_RQS_BIT));
      end
   end

   // ********************************
   // Controller configuration
   // ********************************
   logic                alm_en_q [2];
   logic [2:0]          alm_src_q [2];
   logic                alm_latch_q [2];
   logic signed [W-1:0] alm_hi_val_q [2];
   logic signed [W-1:0] alm_lo_val_q [2];
   logic signed [W-1:0] alm_db_q [2];
   logic                aux_bip_q, aux_chan_q, sounder_q;
   logic [1:0]          aux_mode_q, bright_q;
   logic [2:0]          aux_src_q, loop_mode_q [2];
   logic signed [W-1:0] aux_hi_q, aux_lo_q, aux_man_q;

   // Alarm settings per input; a bad source leaves everything as it was.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || cmd_rst) begin
         for (int k = 0; k < 2; k++) begin
            alm_en_q[k]     <= 1'b0;
            alm_src_q[k]    <= SRC_RST;
            alm_latch_q[k]  <= 1'b0;
            alm_hi_val_q[k] <= '0;
            alm_lo_val_q[k] <= '0;
            alm_db_q[k]     <= '0;
         end
      end else if (i_cmd_valid && (i_cmd_code == CMD_ALARM_CFG_WR) && src_ok(i_arg_src)) begin
         alm_en_q[i_cmd_sel]     <= i_arg_en;
         alm_src_q[i_cmd_sel]    <= i_arg_src;
         alm_latch_q[i_cmd_sel]  <= i_arg_latch;
         alm_hi_val_q[i_cmd_sel] <= i_val_hi;
         alm_lo_val_q[i_cmd_sel] <= i_val_lo;
         alm_db_q[i_cmd_sel]     <= i_val_db;
      end
   end

   // Analog output settings; mode and source are range checked.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || cmd_rst) begin
         aux_bip_q  <= 1'b0;
         aux_mode_q <= AUX_OFF;
         aux_chan_q <= 1'b0;
         aux_src_q  <= SRC_RST;
         aux_hi_q   <= '0;
         aux_lo_q   <= '0;
         aux_man_q  <= '0;
      end else if (i_cmd_valid && (i_cmd_code == CMD_AUX_CFG_WR) && src_ok(i_arg_src)
                   && (i_arg_num <= 8'(AUX_LOOP))) begin
         aux_bip_q  <= i_arg_en;
         aux_mode_q <= i_arg_num[1:0];
         aux_chan_q <= i_cmd_sel;
         aux_src_q  <= i_arg_src;
         aux_hi_q   <= i_val_hi;
         aux_lo_q   <= i_val_lo;
         aux_man_q  <= i_val_man;
      end
   end

   // Sounder enable and display brightness.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || cmd_rst) begin
         sounder_q <= SOUNDER_RST;
         bright_q  <= BRIGHT_RST;
      end else if (i_cmd_valid && (i_cmd_code == CMD_SOUNDER_WR) && (i_arg_num <= 8'h01)) begin
         sounder_q <= i_arg_num[0];
      end else if (i_cmd_valid && (i_cmd_code == CMD_DISPLAY_WR)
                   && (i_arg_num <= 8'(BRIGHT_MAX))) begin
         bright_q <= i_arg_num[1:0];
      end
   end

   // Loop regulation mode per loop, codes 1 through 6 only.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || cmd_rst) begin
         loop_mode_q[0] <= LOOP_MODE_RST;
         loop_mode_q[1] <= LOOP_MODE_RST;
      end else if (i_cmd_valid && (i_cmd_code == CMD_LOOP_MODE_WR)
                   && (i_arg_num >= 8'(LOOP_MODE_MIN))
                   && (i_arg_num <= 8'(LOOP_MODE_MAX))) begin
         loop_mode_q[i_cmd_sel] <= i_arg_num[2:0];
      end
   end

   // ********************************
   // Latest readings and alarm checking
   // ********************************
   logic signed [W-1:0] rdg_q [2][4];

   // Newest value of each source for each input.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         for (int c = 0; c < 2; c++) begin
            for (int s = 0; s < 4; s++) begin
               rdg_q[c][s] <= '0;
            end
         end
      end else if (i_rdg_valid && src_ok(i_rdg_src)) begin
         rdg_q[i_rdg_chan][2'(i_rdg_src - SRC_MIN)] <= i_rdg_val;
      end
   end

   for (genvar g = 0; g < 2; g++) begin : g_alarm
      logic signed [W:0] v, hi, lo, db;
      logic              hi_hit, lo_hit, hi_gone, lo_gone;

      // Compare one bit wider so threshold plus deadband cannot wrap.
      always_comb begin
         v       = (W+1)'(rdg_q[g][2'(alm_src_q[g] - SRC_MIN)]);
         hi      = (W+1)'(alm_hi_val_q[g]);
         lo      = (W+1)'(alm_lo_val_q[g]);
         db      = (W+1)'(alm_db_q[g]);
         hi_hit  = v > hi;
         lo_hit  = v < lo;
         hi_gone = v <= (hi - db);
         lo_gone = v >= (lo + db);
      end

      // Activation wins over the clear command when the cause persists.
      always_ff @(posedge i_clk) begin
         if (i_sys_rst || cmd_rst || !alm_en_q[g]) begin
            alm_hi_q[g] <= 1'b0;
            alm_lo_q[g] <= 1'b0;
         end else begin
            alm_hi_q[g] <= hi_hit || (alm_hi_q[g] && !cmd_almclr
                                      && (alm_latch_q[g] || !hi_gone));
            alm_lo_q[g] <= lo_hit || (alm_lo_q[g] && !cmd_almclr
                                      && (alm_latch_q[g] || !lo_gone));
         end
      end
   end

   // ********************************
   // Analog output level
   // ********************************
   logic signed [31:0] aux_x, aux_span, aux_pct;
   logic signed [W-1:0] aux_q;

   // Input-follow maps low..high onto 0..100 or -100..+100 percent.
   always_comb begin
      aux_x    = 32'(rdg_q[aux_chan_q][2'(aux_src_q - SRC_MIN)]) - 32'(aux_lo_q);
      aux_span = 32'(aux_hi_q) - 32'(aux_lo_q);
      aux_pct  = 32'sd0;
      case (aux_mode_q)
         AUX_INPUT: begin
            if (aux_span > 32'sd0) begin
               if (aux_bip_q) begin
                  aux_pct = (aux_x * PCT_SPAN2) / aux_span - PCT_FULL;
               end else begin
                  aux_pct = (aux_x * PCT_FULL) / aux_span;
               end
            end
         end
         AUX_MANUAL: aux_pct = 32'(aux_man_q);
         AUX_LOOP:   aux_pct = 32'(i_loop_out);
         default:    aux_pct = 32'sd0;
      endcase
      aux_pct = clamp_pct(aux_pct, aux_bip_q);
      aux_pct = (aux_pct / PCT_STEP) * PCT_STEP;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         aux_q <= '0;
      end else begin
         aux_q <= W'(aux_pct);
      end
   end

   // ********************************
   // Query answers
   // ********************************
   logic                rsp_valid_q, rsp_aux_q;
   logic signed [W-1:0] imm_val, rsp_val_q;
   logic                imm_aux;
   rsac_cmd_e           rsp_code_q;

   // Value of each query taken from present state.
   always_comb begin
      imm_rsp = i_cmd_valid;
      imm_aux = 1'b0;
      imm_val = '0;
      case (i_cmd_code)
         CMD_EVMASK_RD:    imm_val = W'(ev_mask_q);
         CMD_EVFLAGS_RD:   imm_val = W'(ev_flags_q);
         CMD_SRMASK_RD:    imm_val = W'(sr_mask_q);
         CMD_STATUS_RD:    imm_val = W'(status_byte);
         CMD_SELFTEST_RD:  imm_val = W'(tst_fail_q);
         CMD_AUX_LEVEL_RD: imm_val = aux_q;
         CMD_SOUNDER_RD:   imm_val = W'(sounder_q);
         CMD_DISPLAY_RD:   imm_val = W'(bright_q);
         CMD_LOOP_MODE_RD: imm_val = W'(loop_mode_q[i_cmd_sel]);
         CMD_ALARM_STATE: begin
            imm_val = W'(alm_hi_q[i_cmd_sel]);
            imm_aux = alm_lo_q[i_cmd_sel];
         end
         default: imm_rsp = 1'b0;
      endcase
   end

   // Immediate answers go first; a pending completion answer follows.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rsp_valid_q <= 1'b0;
         rsp_code_q  <= CMD_NONE;
         rsp_val_q   <= '0;
         rsp_aux_q   <= 1'b0;
      end else if (imm_rsp) begin
         rsp_valid_q <= 1'b1;
         rsp_code_q  <= i_cmd_code;
         rsp_val_q   <= imm_val;
         rsp_aux_q   <= imm_aux;
      end else if (done_rsp && !cmd_clr) begin
         rsp_valid_q <= 1'b1;
         rsp_code_q  <= CMD_DONE_RD;
         rsp_val_q   <= W'(1);
         rsp_aux_q   <= 1'b0;
      end else begin
         rsp_valid_q <= 1'b0;
      end
   end

   // ********************************
   // Registered outputs
   // ********************************
   logic sound_q;

   // Sounder drives only while enabled and some alarm is active.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         sound_q <= 1'b0;
      end else begin
         sound_q <= sounder_q && (|{alm_hi_q, alm_lo_q});
      end
   end

   assign o_rsp_valid     = rsp_valid_q;
   assign o_rsp_code      = rsp_code_q;
   assign o_rsp_val       = rsp_val_q;
   assign o_rsp_aux       = rsp_aux_q;
   assign o_srq           = srq_q;
   assign o_alarm_hi      = alm_hi_q;
   assign o_alarm_lo      = alm_lo_q;
   assign o_sounder       = sound_q;
   assign o_display_level = bright_q;
   assign o_loop1_mode    = loop_mode_q[0];
   assign o_loop2_mode    = loop_mode_q[1];
   assign o_aux_level     = aux_q;

endmodule

/* File: verification/rsac_host.sv */
module rsac_host
   import rsac_pkg::*;
(
   input  wire logic          i_clk,
   output logic               o_cmd_valid,
   output rsac_pkg::rsac_cmd_e o_cmd_code,
   output logic               o_cmd_sel,
   output logic [7:0]         o_arg_num
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle command port from time zero.
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd_code  = CMD_NONE;
      o_cmd_sel   = 1'b0;
      o_arg_num   = 8'h00;
   end

   // Presents one parsed command for one cycle; released arguments show a changed pattern.
   task automatic send(input rsac_cmd_e c, input logic s, input logic [7:0] a);
      @(posedge i_clk);
      #10;
      o_cmd_valid = 1'b1;
      o_cmd_code  = c;
      o_cmd_sel   = s;
      o_arg_num   = a;
      @(posedge i_clk);
      #10;
      o_cmd_valid = 1'b0;
      o_cmd_code  = CMD_NONE;
      o_arg_num   = ~a;
   endtask
endmodule

/* File: verification/rsac_cmd_core_chk.sv */
module rsac_cmd_core_chk
   import rsac_pkg::*;
#(
   parameter int W = rsac_pkg::VAL_W
) (
   input wire logic                 i_clk,
   input wire logic                 i_sys_rst,
   input wire logic                 i_cmd_valid,
   input wire rsac_pkg::rsac_cmd_e  i_cmd_code,
   input wire logic                 i_cmd_sel,
   input wire logic [7:0]           i_arg_num,
   input wire logic                 i_op_busy,
   input wire logic                 o_rsp_valid,
   input wire rsac_pkg::rsac_cmd_e  o_rsp_code,
   input wire logic signed [W-1:0]  o_rsp_val,
   input wire logic [1:0]           o_display_level,
   input wire logic [2:0]           o_loop1_mode,
   input wire logic signed [W-1:0]  o_aux_level
);
   // ********************************
   // Command port and output level properties
   // ********************************
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   // A command of the given code is taken at this edge.
   sequence s_cmd(rsac_cmd_e c);
      i_cmd_valid && i_cmd_code == c;
   endsequence

   AST_EVMASK_ANSWER: assert property (s_cmd(CMD_EVMASK_RD) |=>
      o_rsp_valid && o_rsp_code == CMD_EVMASK_RD) else $error("mask query not answered");
   AST_DISPLAY_SET: assert property (s_cmd(CMD_DISPLAY_WR) ##0 i_arg_num <= 8'h03 |=>
      o_display_level == $past(i_arg_num[1:0])) else $error("brightness not stored");
   AST_DISPLAY_KEEP: assert property (s_cmd(CMD_DISPLAY_WR) ##0 i_arg_num > 8'h03 |=>
      $stable(o_display_level)) else $error("bad brightness accepted");
   AST_LOOP1_SET: assert property (s_cmd(CMD_LOOP_MODE_WR) ##0
      (!i_cmd_sel && i_arg_num inside {[1:6]}) |=> o_loop1_mode == $past(i_arg_num[2:0]))
      else $error("loop mode not stored");
   AST_SELFTEST: assert property (s_cmd(CMD_SELFTEST_RD) |=>
      o_rsp_valid && o_rsp_val inside {0, 1}) else $error("self-test answer out of range");
   AST_RESET_DEFAULTS: assert property (s_cmd(CMD_RESET) |=>
      o_display_level == BRIGHT_RST && o_loop1_mode == LOOP_MODE_RST) else $error("no defaults");
   AST_AUX_STEP: assert property (o_aux_level % 5 == 0)
      else $error("output level off the half percent grid");
   AST_DONE_WAIT: assert property (s_cmd(CMD_DONE_RD) ##0 i_op_busy ##1 i_op_busy |=>
      !(o_rsp_valid && o_rsp_code == CMD_DONE_RD)) else $error("completion answered while busy");
endmodule

bind rsac_cmd_core rsac_cmd_core_chk #(.W(W)) u_rsac_cmd_core_chk (.i_clk, .i_sys_rst,
   .i_cmd_valid, .i_cmd_code, .i_cmd_sel, .i_arg_num, .i_op_busy, .o_rsp_valid, .o_rsp_code,
   .o_rsp_val, .o_display_level, .o_loop1_mode, .o_aux_level);

/* File: verification/rsac_cmd_core_test.sv */
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
   $display("[FAIL] %s expected %0d seen %0d", n, e, a); end end

module rsac_cmd_core_test;
   import rsac_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk, i_sys_rst, i_cmd_valid, i_cmd_sel, i_op_busy, i_arg_latch, i_rdg_valid, i_rdg_chan;
   logic i_arg_en, i_dev_err, i_exe_err, i_selftest_fail, o_rsp_valid, o_rsp_aux, o_srq, o_sounder;
   rsac_cmd_e          i_cmd_code, o_rsp_code;
   logic [7:0]         i_arg_num, x;
   logic [2:0]         i_arg_src, i_rdg_src, o_loop1_mode, o_loop2_mode, e1, e2;
   logic [1:0]         o_alarm_hi, o_alarm_lo, o_display_level, d;
   logic signed [15:0] i_val_hi, i_val_lo, i_val_db, i_val_man, i_rdg_val, i_loop_out;
   logic signed [15:0] o_rsp_val, o_aux_level;
   logic [31:0]        seed;
   int                 n_errors, comparisons, k;

   rsac_host u_rsac_host (.i_clk, .o_cmd_valid(i_cmd_valid), .o_cmd_code(i_cmd_code),
      .o_cmd_sel(i_cmd_sel), .o_arg_num(i_arg_num));
   rsac_cmd_core u_rsac_cmd_core (.i_clk, .i_sys_rst, .i_cmd_valid, .i_cmd_code, .i_cmd_sel,
      .i_arg_num, .i_arg_en, .i_arg_src, .i_arg_latch, .i_val_hi, .i_val_lo, .i_val_db, .i_val_man,
      .i_rdg_valid, .i_rdg_chan, .i_rdg_src, .i_rdg_val, .i_loop_out, .i_op_busy, .i_dev_err,
      .i_exe_err, .i_selftest_fail, .o_rsp_valid, .o_rsp_code, .o_rsp_val, .o_rsp_aux, .o_srq,
      .o_alarm_hi, .o_alarm_lo, .o_sounder, .o_display_level, .o_loop1_mode, .o_loop2_mode,
      .o_aux_level);

   // ********************************
   // Helpers
   // ********************************
   // Xorshift source of repeatable random values.
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected code after a write: out-of-range values leave the old one.
   function automatic logic [2:0] keep(int c, int lo, int hi, logic [2:0] old);
      return (c >= lo && c <= hi) ? 3'(c) : old;
   endfunction
   // Query, then check the answer of the following cycle.
   task automatic q(input string n, input rsac_cmd_e c, input logic s, input int e);
      u_rsac_host.send(c, s, 8'h00);
      `CHK(n, 1'b1, o_rsp_valid)
      `CHK(n, 16'(e), o_rsp_val)
   endtask
   // One new reading on input A, kelvin, then time for it to settle.
   task automatic rd(input int v);
      @(posedge i_clk);
      #10;
      i_rdg_valid = 1'b1;
      i_rdg_val   = 16'(v);
      @(posedge i_clk);
      #10;
      i_rdg_valid = 1'b0;
      i_rdg_val   = ~16'(v);
      repeat (3) @(posedge i_clk);
      #10;
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Free-running 100 ns clock.
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   // Watchdog well beyond the expected run length.
   initial begin
      #2000000;
      n_errors++;
      summarize();
   end

   // ********************************
   // Scenarios
   // ********************************
   initial begin
      seed = 32'h0507e558;
      {i_sys_rst, i_arg_en, i_arg_latch, i_rdg_valid, i_rdg_chan, i_op_busy} = 6'b100000;
      {i_dev_err, i_exe_err, i_selftest_fail, i_arg_src, i_rdg_src} = {3'b000, 3'h1, 3'h1};
      {i_val_hi, i_val_lo, i_val_db, i_val_man, i_rdg_val, i_loop_out} = '0;
      repeat (10) @(posedge i_clk);
      #10;
      i_sys_rst = 1'b0;
      `CHK("bright_rst", 2'h2, o_display_level)
      `CHK("loop_rst", 3'h1, o_loop1_mode)
      q("power_on", CMD_EVFLAGS_RD, 1'b0, 128);
      q("read_clear", CMD_EVFLAGS_RD, 1'b0, 0);
      u_rsac_host.send(CMD_EVMASK_WR, 1'b0, 8'h8f);
      q("ev_mask", CMD_EVMASK_RD, 1'b0, 143);
      x = 8'(rnd());
      u_rsac_host.send(CMD_SRMASK_WR, 1'b0, x);
      q("sr_mask", CMD_SRMASK_RD, 1'b0, int'(x));
      q("self_test", CMD_SELFTEST_RD, 1'b0, 0);
      $display("test status_masks done");
      d = 2'h2;
      for (k = 0; k < 5; k++) begin
         u_rsac_host.send(CMD_DISPLAY_WR, 1'b0, 8'(k));
         d = 2'(keep(k, 0, 3, {1'b0, d}));
         `CHK("bright", d, o_display_level)
      end
      q("bright_rd", CMD_DISPLAY_RD, 1'b0, int'(d));
      {e1, e2} = {3'h1, 3'h1};
      for (k = 0; k < 16; k++) begin
         u_rsac_host.send(CMD_LOOP_MODE_WR, k >= 8, 8'(k % 8));
         if (k < 8) e1 = keep(k % 8, 1, 6, e1);
         else e2 = keep(k % 8, 1, 6, e2);
         `CHK("loop1", e1, o_loop1_mode)
         `CHK("loop2", e2, o_loop2_mode)
      end
      q("loop2_rd", CMD_LOOP_MODE_RD, 1'b1, int'(e2));
      $display("test settings done");
      {i_arg_en, i_val_hi, i_val_lo, i_val_db} = {1'b1, 16'sd100, 16'sd0, 16'sd10};
      u_rsac_host.send(CMD_ALARM_CFG_WR, 1'b0, 8'h00);
      rd(101 + int'(rnd() % 50));
      `CHK("hi_on", 1'b1, o_alarm_hi[0])
      `CHK("sound_on", 1'b1, o_sounder)
      q("state_hi", CMD_ALARM_STATE, 1'b0, 1);
      `CHK("state_lo", 1'b0, o_rsp_aux)
      rd(91);
      `CHK("deadband_hold", 1'b1, o_alarm_hi[0])
      rd(90);
      `CHK("deadband_free", 1'b0, o_alarm_hi[0])
      i_arg_latch = 1'b1;
      u_rsac_host.send(CMD_ALARM_CFG_WR, 1'b0, 8'h00);
      rd(-1);
      `CHK("lo_on", 1'b1, o_alarm_lo[0])
      rd(50);
      `CHK("latched", 1'b1, o_alarm_lo[0])
      u_rsac_host.send(CMD_SOUNDER_WR, 1'b0, 8'h00);
      q("status", CMD_STATUS_RD, 1'b0, 8 + (x[3] ? 64 : 0));
      q("status_again", CMD_STATUS_RD, 1'b0, 8 + (x[3] ? 64 : 0));
      `CHK("sound_off", 1'b0, o_sounder)
      `CHK("srq", x[3], o_srq)
      u_rsac_host.send(CMD_ALARM_CLEAR, 1'b0, 8'h00);
      `CHK("alarm_clear", 1'b0, o_alarm_lo[0])
      $display("test alarms done");
      i_op_busy = 1'b1;
      u_rsac_host.send(CMD_DONE_RD, 1'b0, 8'h00);
      repeat (3) begin
         `CHK("done_early", 1'b0, o_rsp_valid)
         @(posedge i_clk);
         #10;
      end
      i_op_busy = 1'b0;
      for (k = 0; k < 4 && o_rsp_valid !== 1'b1; k++) begin
         @(posedge i_clk);
         #10;
      end
      `CHK("done_answer", 16'sd1, o_rsp_val)
      u_rsac_host.send(CMD_DONE_WR, 1'b0, 8'h00);
      q("done_flag", CMD_EVFLAGS_RD, 1'b0, 1);
      u_rsac_host.send(CMD_DONE_WR, 1'b0, 8'h00);
      u_rsac_host.send(CMD_CLEAR_STATUS, 1'b0, 8'h00);
      q("cleared", CMD_EVFLAGS_RD, 1'b0, 0);
      `CHK("cls_keeps", d, o_display_level)
      u_rsac_host.send(CMD_RESET, 1'b0, 8'h00);
      `CHK("rst_bright", 2'h2, o_display_level)
      `CHK("rst_loop2", 3'h1, o_loop2_mode)
      $display("test completion_reset done");
      {i_arg_en, i_val_hi} = {1'b0, 16'sd300};
      u_rsac_host.send(CMD_AUX_CFG_WR, 1'b0, 8'h01);
      rd(100);
      q("aux_pos", CMD_AUX_LEVEL_RD, 1'b0, 330);
      `CHK("aux_out", 16'sd330, o_aux_level)
      i_arg_en = 1'b1;
      u_rsac_host.send(CMD_AUX_CFG_WR, 1'b0, 8'h01);
      rd(100);
      q("aux_bip", CMD_AUX_LEVEL_RD, 1'b0, -330);
      $display("test aux_output done");
      summarize();
   end
endmodule
